//--- include/hsp_pkg.sv
// package for the port a configuration register bank
// Overview of operation
// - writing one to soft reset resets port state machines, bit self-clears
// - with port enable zero the port ignores its pins and the insertion input and takes in no cells
// - configured invalid flag goes into every 130-byte cell written in from the pins
// - inserted cells always carry invalid flag of one
// - counter enable one counts 23-bit counter on each external tick, zero holds it at zero
// - sync mode field 14:13 selects mode a, b, c; 11 is reserved
// - reserved bits 29:18 ignore writes and read zero
// - buffer map bits mark buffers of this port, buffers 0 and 1 at reset
// - serial mode bit one makes port take data on lowest pin only
package hsp_pkg;
  localparam logic [7:0] OFF_CFG0 = 8'h80;
  localparam logic [7:0] OFF_CFG1 = 8'h84;
  localparam logic [7:0] OFF_EVT = 8'h88;
  localparam logic [7:0] OFF_EVTEN = 8'h8c;
  localparam logic [7:0] OFF_MASK = 8'h90;
  localparam logic [7:0] OFF_ROUTE0 = 8'h94;
  localparam logic [7:0] OFF_ROUTE1 = 8'h98;
  localparam logic [7:0] OFF_FWIN = 8'h9c;
  localparam logic [7:0] OFF_FCTL = 8'ha0;
  localparam logic [7:0] OFF_IWIN = 8'ha4;
  localparam logic [7:0] OFF_ICTL0 = 8'ha8;
  localparam logic [7:0] OFF_ICTL1 = 8'hac;
  localparam logic [7:0] OFF_STAT = 8'hc0;
  localparam int B_RST = 31;
  localparam int B_EN = 30;
  localparam int B_SIF = 17;
  localparam int B_SCC = 16;
  localparam int B_SER = 8;
  localparam logic [31:0] CFG0_WMASK = 32'h4003_ffff;
  localparam logic [31:0] CFG0_RST = 32'h0000_0003;
  localparam logic [31:0] CFG1_WMASK = 32'h0000_5fff;
  localparam logic [22:0] CNT_ZERO = 23'h00_0000;
  localparam logic [1:0] SYNC_RESERVED_BLOCK = 2'h3;
  typedef enum logic [1:0] {HSP_SYNC_A, HSP_SYNC_B, HSP_SYNC_C,
    HSP_SYNC_X} hsp_sync_t;
  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic ins;
    logic [2:0] buf_idx;
  } hsp_word_t;
  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic ins;
    logic timestamp_invalid_flag;
    logic [2:0] buf_idx;
  } hsp_cell_t;
endpackage

//--- rtl/hsp_port_a.sv
// port a configuration registers and data front end
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module hsp_port_a
  import hsp_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic i_pin_valid,
  input wire logic [7:0] i_pin_data,
  input wire logic i_pin_last,
  input wire logic [2:0] i_pin_buf,
  output logic o_pin_ready,
  input wire logic i_ins_valid,
  input wire logic [7:0] i_ins_data,
  input wire logic i_ins_last,
  output logic o_ins_ready,
  input wire logic i_ext_clk_tick,
  output logic o_cell_valid,
  output var hsp_cell_t o_cell,
  input wire logic i_cell_ready,
  output logic [22:0] o_sys_count,
  output logic [1:0] o_sync_mode,
  output logic o_cell130_filter_option
);
  logic [31:0] cfg0;
  logic [31:0] cfg1;
  logic [31:0] gen_reg [0:9];
  logic soft_rst;
  logic wr_en;
  logic rd_en;
  logic [3:0] gidx;
  logic gsel;
  logic [7:0] ser_sh;
  logic [2:0] ser_cnt;
  logic in_v;
  hsp_word_t in_w;
  logic in_rdy;
  hsp_cell_t buf_q [0:1];
  logic [1:0] cnt_q;
  logic wp;
  logic rp;
  logic [22:0] sys_cnt;
  logic [15:0] words_in;
  logic [7:0] ser_byte_next;
  logic port_en;
  logic [31:0] rd_mux;

  function automatic logic [3:0] gen_index(input logic [7:0] a);
    gen_index = 4'((a - OFF_EVT) >> 2);
  endfunction

  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~pwrite;
  assign gidx = gen_index(paddr);
  assign gsel = (paddr >= OFF_EVT) && (paddr <= OFF_ICTL1)
    && (paddr[1:0] == 2'h0);
  assign pslverr = psel & penable & ~(gsel || paddr == OFF_CFG0 ||
    paddr == OFF_CFG1 || (paddr >= 8'hb0 && paddr <= 8'hbf) ||
    paddr == OFF_STAT);
  assign port_en = cfg0[B_EN];
  assign o_sync_mode = cfg0[14:13];
  assign o_cell130_filter_option = cfg0[12];
  assign o_sys_count = sys_cnt;

  // configuration word 0 with self-clearing soft reset
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg0 <= CFG0_RST;
    end else if (wr_en && paddr == OFF_CFG0) begin
      cfg0 <= pwdata & CFG0_WMASK;
    end
  end

  // soft reset pulse, read always returns zero
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= wr_en && paddr == OFF_CFG0 && pwdata[B_RST];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg1 <= 32'h0000_0000;
    end else if (wr_en && paddr == OFF_CFG1) begin
      cfg1 <= pwdata & CFG1_WMASK;
    end
  end

  // remaining words are plain storage for other functions
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < 10; i++) begin
        gen_reg[i] <= 32'h0000_0000;
      end
    end else if (wr_en && gsel) begin
      gen_reg[gidx] <= pwdata;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (paddr == OFF_CFG0) begin
      rd_mux = cfg0;
    end else if (paddr == OFF_CFG1) begin
      rd_mux = cfg1;
    end else if (gsel) begin
      rd_mux = gen_reg[gidx];
    end else if (paddr == OFF_STAT) begin
      rd_mux = {words_in, 14'h0000, cnt_q};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en && !penable) begin
      prdata <= rd_mux;
    end
  end

  // system clock counter on external tick
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sys_cnt <= CNT_ZERO;
    end else if (!cfg0[B_SCC] || soft_rst) begin
      sys_cnt <= CNT_ZERO;
    end else if (i_ext_clk_tick) begin
      sys_cnt <= sys_cnt + 23'h00_0001;
    end
  end

  // serial deserialiser on lowest data pin
  assign ser_byte_next = cfg0[9] ? {i_pin_data[0], ser_sh[7:1]}
    : {ser_sh[6:0], i_pin_data[0]};
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ser_sh <= 8'h00;
      ser_cnt <= 3'h0;
    end else if (soft_rst || !port_en || !cfg0[B_SER]) begin
      ser_sh <= 8'h00;
      ser_cnt <= 3'h0;
    end else if (i_pin_valid && o_pin_ready && pin_ok) begin
      ser_sh <= ser_byte_next;
      ser_cnt <= ser_cnt + 3'h1;
    end
  end

  // pick source: insertion first, then pins
  logic pin_ok;
  logic filt_ok;
  assign filt_ok = !cfg0[12] || o_sync_mode != SYNC_RESERVED_BLOCK;
  assign pin_ok = port_en && cfg0[i_pin_buf] && filt_ok;
  always_comb begin
    in_v = 1'b0;
    in_w = '0;
    if (port_en && i_ins_valid) begin
      in_v = 1'b1;
      in_w = '{data: i_ins_data, last: i_ins_last, ins: 1'b1,
        buf_idx: 3'h0};
    end else if (pin_ok && i_pin_valid) begin
      in_v = !cfg0[B_SER] || ser_cnt == 3'h7;
      in_w = '{data: cfg0[B_SER] ? ser_byte_next : i_pin_data,
        last: i_pin_last, ins: 1'b0, buf_idx: i_pin_buf};
    end
  end
  assign in_rdy = cnt_q != 2'h2;
  assign o_ins_ready = port_en && in_rdy;
  assign o_pin_ready = port_en && in_rdy && !i_ins_valid;

  // two-entry buffer toward the receiver
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      buf_q[0] <= '0;
      buf_q[1] <= '0;
      wp <= 1'b0;
      rp <= 1'b0;
      cnt_q <= 2'h0;
      words_in <= 16'h0000;
    end else if (soft_rst) begin
      wp <= 1'b0;
      rp <= 1'b0;
      cnt_q <= 2'h0;
      words_in <= 16'h0000;
    end else begin
      if (in_v && in_rdy) begin
        buf_q[wp] <= '{data: in_w.data, last: in_w.last, ins: in_w.ins,
          timestamp_invalid_flag: in_w.ins ? 1'b1 : cfg0[B_SIF],
          buf_idx: in_w.buf_idx};
        wp <= ~wp;
        words_in <= words_in + 16'h0001;
      end
      if (o_cell_valid && i_cell_ready) begin
        rp <= ~rp;
      end
      cnt_q <= cnt_q + 2'((in_v && in_rdy) ? 1 : 0)
        - 2'((o_cell_valid && i_cell_ready) ? 1 : 0);
    end
  end
  assign o_cell_valid = cnt_q != 2'h0;
  assign o_cell = buf_q[rp];
endmodule
`default_nettype wire

//--- tb/hsp_port_a_properties.sv
// checker on the port a bank ports
`timescale 1ns/1ps
`default_nettype none
module hsp_port_a_properties
  import hsp_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic i_ins_valid,
  input wire logic i_ext_clk_tick,
  input wire logic o_cell_valid,
  input wire hsp_cell_t o_cell,
  input wire logic i_cell_ready,
  input wire logic [22:0] o_sys_count
);
  logic [31:0] cfg;
  wire acc = psel && penable;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  // shadow of config word 0 as written
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) cfg <= CFG0_RST;
    else if (acc && pwrite && paddr == OFF_CFG0) cfg <= pwdata;
  end
  a_reserved_block_read: assert property (acc && !pwrite && paddr == OFF_CFG0
    |-> !prdata[31] && prdata[29:18] == 12'h000) else $error("reserved_block bits");
  a_count_step: assert property (##1 o_sys_count == CNT_ZERO ||
    o_sys_count == $past(o_sys_count) + 23'($past(i_ext_clk_tick)))
    else $error("count step");
  a_count_off: assert property (!cfg[B_SCC]
    |=> o_sys_count == CNT_ZERO) else $error("count held");
  a_ins_sif: assert property (o_cell_valid && o_cell.ins
    |-> o_cell.timestamp_invalid_flag) else $error("insert flag");
  a_cell_sif: assert property (o_cell_valid && !o_cell.ins
    |-> o_cell.timestamp_invalid_flag == cfg[B_SIF]) else $error("cell flag");
  a_buf_mapped: assert property (o_cell_valid && !o_cell.ins
    |-> cfg[o_cell.buf_idx]) else $error("unmapped buffer");
  a_pins_off: assert property (!cfg[B_EN] && !i_ins_valid
    && !o_cell_valid |=> !o_cell_valid) else $error("pins not ignored");
  a_cell_hold: assert property (o_cell_valid && !i_cell_ready
    |=> o_cell_valid && $stable(o_cell)) else $error("cell lost");
endmodule
bind hsp_port_a hsp_port_a_properties u_props (.*);
`default_nettype wire

//--- tb/hsp_sink.sv
// cell sink that stalls on request
`timescale 1ns/1ps
`default_nettype none
module hsp_sink (
  input wire logic i_sys_clk,
  input wire logic i_stall,
  output logic o_cell_ready
);
  always_ff @(posedge i_sys_clk) o_cell_ready <= !i_stall;
endmodule
`default_nettype wire

//--- tb/test_hsp_port_a.sv
// bench for the port a register bank
`timescale 1ns/1ps
`default_nettype none
module test_hsp_port_a;
  import hsp_pkg::*;
  logic i_sys_clk = 1'h0, i_arst_n = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, i_pin_valid = 1'h1, i_ins_valid = 1'h0, stall = 1'h1;
  logic i_pin_last = 1'h1, i_ins_last = 1'h1, i_ext_clk_tick = 1'h0;
  logic [7:0] paddr = 8'h00, i_pin_data = 8'h00, i_ins_data = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, o_pin_ready, o_ins_ready, o_cell_valid, i_cell_ready;
  logic o_cell130_filter_option;
  logic [2:0] i_pin_buf = 3'h0;
  logic [1:0] o_sync_mode;
  logic [22:0] o_sys_count;
  hsp_cell_t o_cell;
  int err_total = 0, n_tests = 0, n;
  wire [3:0] rdy = {o_cell_valid & i_cell_ready, o_ins_ready, o_pin_ready,
    pready};
  hsp_port_a u_dut (.*);
  hsp_sink u_sink (.i_sys_clk, .i_stall(stall), .o_cell_ready(i_cell_ready));
  initial forever #5 i_sys_clk = ~i_sys_clk;
  task results;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %0t: got %h want %h", $time, g, e);
    end
  endtask
  task await(input int s);
    for (n = 0; n < 8; n++) @(posedge i_sys_clk) if (rdy[s] === 1'h1) break;
    chk(n < 8, 1'h1);
    if (n == 8) results;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk) {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge i_sys_clk) penable <= 1'h1;
    await(0);
    rd = prdata;
    {psel, penable} <= 2'h0;
  endtask
  task push(input logic ins, input logic [7:0] d, input logic [2:0] b);
    @(posedge i_sys_clk) {i_pin_valid, i_ins_valid, i_pin_data, i_ins_data,
      i_pin_buf} <= {!ins, ins, d, d, b};
    await(ins ? 2 : 1);
    {i_pin_valid, i_ins_valid} <= 2'h0;
  endtask
  task take(input logic [10:0] e);
    await(3);
    chk(o_cell[13:3], e);
  endtask
  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_arst_n <= 1'h1;
    apb(1'h0, OFF_CFG0, 32'h0);
    chk(rd, CFG0_RST);
    chk(o_cell_valid, 1'h0);
    i_pin_valid <= 1'h0;
    for (int s = 0; s < 4; s++) begin
      apb(1'h1, OFF_CFG0, 32'h7fff_1fff | (s << 13));
      apb(1'h0, OFF_CFG0, 32'h0);
      chk(rd, 32'h4003_1fff | (s << 13));
      chk(o_sync_mode, s);
      chk(o_cell130_filter_option, 1'h1);
    end
    apb(1'h1, OFF_CFG0, 32'h4002_0003);
    push(1'h0, 8'ha5, 3'h0);
    push(1'h0, 8'h5a, 3'h1);
    @(posedge i_sys_clk) i_pin_valid <= 1'h1;
    @(posedge i_sys_clk) chk(o_pin_ready, 1'h0);
    {i_pin_valid, stall} <= 2'h0;
    take({8'ha5, 1'h1, 1'h0, 1'h1});
    take({8'h5a, 1'h1, 1'h0, 1'h1});
    apb(1'h1, OFF_CFG0, 32'h4000_0003);
    push(1'h1, 8'h3c, 3'h0);
    take({8'h3c, 1'h1, 1'h1, 1'h1});
    apb(1'h1, OFF_CFG0, 32'h4000_0103);
    for (int b = 7; b >= 0; b--) begin
      push(1'h0, {7'h00, b % 2 == 0}, 3'h0);
    end
    take({8'h55, 1'h1, 1'h0, 1'h0});
    apb(1'h1, OFF_CFG0, 32'h4001_0003);
    repeat (10) @(posedge i_sys_clk) i_ext_clk_tick <= !i_ext_clk_tick;
    @(posedge i_sys_clk) chk(o_sys_count, 23'h5);
    apb(1'h1, OFF_CFG0, 32'hc001_0003);
    apb(1'h0, OFF_CFG0, 32'h0);
    chk(rd, 32'h4001_0003);
    chk(o_sys_count, 23'h0);
    results;
  end
endmodule
`default_nettype wire
